// ### shared/cvdpas_pkg.sv
// Package for the capacitive-divider precharge/acquisition sequencer.
// Assumes a single 50 MHz converter clock and a synchronous active-high reset.
package cvdpas_pkg;

  // Register map of the plain register port (word addresses).
  localparam logic [3:0] CVDPAS_ADDR_CTRL = 4'h0;
  localparam logic [3:0] CVDPAS_ADDR_PRE = 4'h1;
  localparam logic [3:0] CVDPAS_ADDR_ACQ = 4'h2;
  localparam logic [3:0] CVDPAS_ADDR_CAP = 4'h3;
  localparam logic [3:0] CVDPAS_ADDR_STATUS = 4'h4;

  // Control register bit positions.
  localparam int CVDPAS_BIT_START = 0;
  localparam int CVDPAS_BIT_PRECHARGE_POLARITY = 1;
  localparam int CVDPAS_BIT_GPOL = 2;
  localparam int CVDPAS_BIT_IPEN = 3;
  localparam int CVDPAS_BIT_DSEN = 4;
  localparam int CVDPAS_BIT_ACQ_DONE = 5;

  // Reset values.
  localparam logic [7:0] CVDPAS_PRE_RESET = 8'h00;
  localparam logic [12:0] CVDPAS_ACQ_RESET = 13'h0000;
  localparam logic [5:0] CVDPAS_CAP_RESET = 6'h00;
  localparam logic [4:0] CVDPAS_CTRL_RESET = 5'h00;

  // Longest acquisition when precharge is on and the acquisition count is zero.
  localparam logic [12:0] CVDPAS_ACQ_MAX = 13'h1FFF;

  // Counter widths.
  localparam int CVDPAS_PRE_W = 8;
  localparam int CVDPAS_ACQ_W = 13;
  localparam int CVDPAS_CAP_W = 6;

  typedef enum logic [2:0] {
    CVDPAS_IDLE,
    CVDPAS_PRECHARGE,
    CVDPAS_ACQUIRE,
    CVDPAS_CONVERT
  } cvdpas_phase_t;

  // Analog switch controls toward the sample path.
  typedef struct packed {
    logic hold_isolate;
    logic hold_to_vdd;
    logic hold_to_vss;
    logic channel_connect;
    logic pin_force_en;
    logic pin_force_level;
    logic [CVDPAS_CAP_W-1:0] extra_cap;
  } cvdpas_analog_t;

  // Guard-ring outputs.
  typedef struct packed {
    logic guard_out_a;
    logic guard_out_b;
  } cvdpas_guard_t;

  // Register port request.
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } cvdpas_reg_req_t;

endpackage

// ### rtl/cvdpas_phase_timer.sv
// Down-counter that times one sequencer phase.
// Assumes load is pulsed in the cycle before the phase it times starts.
module cvdpas_phase_timer
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Control
  input wire logic load_i,
  input wire logic [12:0] count_i,
  input wire logic run_i,
  // Status
  output logic expire_o
);
  import cvdpas_pkg::*;

  logic [12:0] count_reg;
  logic [12:0] count_next;

  // Expiry is seen while the count is one, so a count of N lasts N cycles.
  assign expire_o = run_i && (count_reg == 13'h0001);
  assign count_next = load_i ? count_i : (run_i && count_reg != 13'h0000) ? count_reg - 13'h0001 : count_reg;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      count_reg <= 13'h0000;
    else
      count_reg <= count_next;
  end
endmodule

// ### rtl/cvdpas_guard_drive.sv
// Guard-ring output driver for the capacitive divider sequencer.
// Assumes the sequencer flags phase starts with one-cycle pulses.
module cvdpas_guard_drive
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Settings
  input wire logic guard_polarity_i,
  input wire logic second_sample_invert_enable_i,
  // Phase start pulses
  input wire logic pre_start_i,
  input wire logic acq_start_i,
  input wire logic second_i,
  // Outputs
  output cvdpas_pkg::cvdpas_guard_t guard_o
);
  import cvdpas_pkg::*;

  cvdpas_guard_t guard_reg;
  cvdpas_guard_t guard_next;
  logic second_level;

  // Second precharge inverts both levels only when invert is enabled.
  assign second_level = (second_i && second_sample_invert_enable_i) ? ~guard_polarity_i : guard_polarity_i; // [RULE14]

  always_comb
  begin
    guard_next = guard_reg;
    if (pre_start_i)
    begin
      guard_next.guard_out_a = second_level; // [RULE12]
      guard_next.guard_out_b = second_level; // [RULE12]
    end
    else if (acq_start_i)
      guard_next.guard_out_a = ~guard_reg.guard_out_a; // [RULE13]
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      guard_reg <= '0;
    else
      guard_reg <= guard_next; // [RULE11]
  end

  assign guard_o = guard_reg;
endmodule

// ### rtl/cvdpas_sequencer.sv
// Capacitive divider precharge/acquisition sequencer top level.
// Assumes the converter core signals conversion completion with conv_done_i.
// Triggers and restarts are one-cycle pulses synchronous to clk_i.

// How it works
// RULE1: Precharge runs only if precharge count is non-zero at conversion start.
// RULE2: Software start, special trigger or computation restart each begin precharge.
// RULE3: Precharge isolates hold capacitor and ties it to supply or ground by polarity.
// RULE4: Precharge forces the channel pin to the level opposite the hold capacitor.
// RULE5: Precharge length comes from the precharge count register.
// RULE6: Precharge pin drive overrides the pin direction setting.
// RULE7: Acquisition starts at conversion start, or right after precharge ends.
// RULE8: Acquisition turns off forced pin drivers and connects channel to hold capacitor.
// RULE9: With precharge on and acquisition count zero, acquire for 8191 cycles.
// RULE10: With precharge off and acquisition count zero, software times acquisition.
// RULE11: Two guard outputs, polarity set by guard polarity and invert enable.
// RULE12: First precharge start sets both guard outputs to guard polarity.
// RULE13: Acquisition start inverts guard A and leaves guard B.
// RULE14: With invert enabled, second precharge drives guards opposite; A toggles again.
// RULE15: Differential measurement repeats the sequence with precharge levels inverted.
// RULE16: Precharge end releases supply/ground paths and reconnects sensor path.
// RULE17: Conversion starts only after acquisition has ended.
// RULE18: Extra hold capacitance connects during sampling, disconnects during conversion.
// RULE19: Double-sample enable gives two successive samples, otherwise one.
// RULE20: One phase at a time, idle-precharge-acquire-convert, zero phases skipped.
module cvdpas_sequencer
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // Conversion triggers
  input wire logic trigger_i,
  input wire logic restart_i,
  // Converter core
  input wire logic conv_done_i,
  output logic conv_start_o,
  output logic busy_o,
  // Analog switch controls
  output logic hold_isolate_o,
  output logic hold_to_vdd_o,
  output logic hold_to_vss_o,
  output logic channel_connect_o,
  output logic [5:0] extra_hold_cap_o,
  // Channel pin override
  input wire logic pin_direction_control_i,
  input wire logic pin_port_out_i,
  output logic pin_out_o,
  output logic pin_oe_o,
  // Guard rings
  output logic guard_out_a_o,
  output logic guard_out_b_o
);
  import cvdpas_pkg::*;

  logic [CVDPAS_PRE_W-1:0] precharge_time_reg;
  logic [CVDPAS_ACQ_W-1:0] acquisition_time_reg;
  logic [CVDPAS_CAP_W-1:0] extra_hold_cap_select_reg;
  logic precharge_polarity_reg;
  logic guard_polarity_reg;
  logic second_sample_invert_enable_reg;
  logic double_sample_enable_reg;
  logic sw_acq_done_reg;
  logic second_reg;
  logic second_next;
  logic pre_active_reg;
  logic pre_active_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  cvdpas_phase_t phase_reg;
  cvdpas_phase_t phase_next;
  cvdpas_analog_t analog_reg;
  cvdpas_analog_t analog_next;
  cvdpas_guard_t guard;

  logic wr_ctrl;
  logic start_req;
  logic begin_conv;
  logic pre_zero;
  logic acq_zero;
  logic sw_acq_done;
  logic pre_expire;
  logic acq_expire;
  logic pre_start;
  logic acq_start;
  logic acq_end;
  logic conv_start;
  logic ctrl_precharge_polarity;
  logic ctrl_gpol;
  logic ctrl_ipen;
  logic conv_pulse_reg;
  logic [12:0] timer_load;
  logic timer_load_en;
  logic timer_run;

  // Register writes.
  assign wr_ctrl = reg_wr_i && (reg_addr_i == CVDPAS_ADDR_CTRL);

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      precharge_time_reg <= CVDPAS_PRE_RESET;
      acquisition_time_reg <= CVDPAS_ACQ_RESET;
      extra_hold_cap_select_reg <= CVDPAS_CAP_RESET;
      {double_sample_enable_reg, second_sample_invert_enable_reg, guard_polarity_reg, precharge_polarity_reg} <= 4'h0;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == CVDPAS_ADDR_CTRL)
      begin
        precharge_polarity_reg <= reg_wdata_i[CVDPAS_BIT_PRECHARGE_POLARITY];
        guard_polarity_reg <= reg_wdata_i[CVDPAS_BIT_GPOL];
        second_sample_invert_enable_reg <= reg_wdata_i[CVDPAS_BIT_IPEN];
        double_sample_enable_reg <= reg_wdata_i[CVDPAS_BIT_DSEN];
      end
      else if (reg_addr_i == CVDPAS_ADDR_PRE)
        precharge_time_reg <= reg_wdata_i[CVDPAS_PRE_W-1:0];
      else if (reg_addr_i == CVDPAS_ADDR_ACQ)
        acquisition_time_reg <= reg_wdata_i[CVDPAS_ACQ_W-1:0];
      else if (reg_addr_i == CVDPAS_ADDR_CAP)
        extra_hold_cap_select_reg <= reg_wdata_i[CVDPAS_CAP_W-1:0];
    end
  end

  // Start sources: software start bit, special event trigger, computation restart.
  assign start_req = (wr_ctrl && reg_wdata_i[CVDPAS_BIT_START]) || trigger_i || restart_i; // [RULE2]
  assign begin_conv = start_req && (phase_reg == CVDPAS_IDLE);
  // Software ends an untimed acquisition by writing the done bit.
  assign sw_acq_done = wr_ctrl && reg_wdata_i[CVDPAS_BIT_ACQ_DONE];

  // Precharge enable is latched per sample in pre_active_reg; the precharge count itself is re-read at each sample start.
  assign pre_zero = (precharge_time_reg == 8'h00); // [RULE1]
  assign acq_zero = (acquisition_time_reg == 13'h0000);

  // A start written together with new settings runs with those settings; the stored
  // copies only land at the same edge, one cycle too late for the first phase.
  assign ctrl_precharge_polarity = wr_ctrl ? reg_wdata_i[CVDPAS_BIT_PRECHARGE_POLARITY] : precharge_polarity_reg; // [RULE3]
  assign ctrl_gpol = wr_ctrl ? reg_wdata_i[CVDPAS_BIT_GPOL] : guard_polarity_reg; // [RULE12]
  assign ctrl_ipen = wr_ctrl ? reg_wdata_i[CVDPAS_BIT_IPEN] : second_sample_invert_enable_reg; // [RULE14]

  // Phase sequencing; zero-length phases fall through in the same cycle.
  always_comb
  begin
    phase_next = phase_reg;
    second_next = second_reg;
    pre_active_next = pre_active_reg;
    pre_start = 1'b0;
    acq_start = 1'b0;
    conv_start = 1'b0;
    case (phase_reg)
      CVDPAS_IDLE:
      begin
        if (begin_conv)
        begin
          second_next = 1'b0;
          pre_active_next = !pre_zero;
          if (!pre_zero)
          begin
            phase_next = CVDPAS_PRECHARGE; // [RULE1] [RULE20]
            pre_start = 1'b1;
          end
          else
          begin
            phase_next = CVDPAS_ACQUIRE; // [RULE7]
            acq_start = 1'b1;
          end
        end
      end
      CVDPAS_PRECHARGE:
      begin
        if (pre_expire)
        begin
          phase_next = CVDPAS_ACQUIRE; // [RULE7]
          acq_start = 1'b1;
        end
      end
      CVDPAS_ACQUIRE:
      begin
        if (acq_end)
        begin
          phase_next = CVDPAS_CONVERT; // [RULE17]
          conv_start = 1'b1;
        end
      end
      CVDPAS_CONVERT:
      begin
        if (conv_done_i)
        begin
          // The second sample re-reads the precharge count, so a zero count skips its precharge too.
          if (double_sample_enable_reg && !second_reg)
          begin
            second_next = 1'b1; // [RULE19]
            pre_active_next = !pre_zero;
            if (!pre_zero)
            begin
              phase_next = CVDPAS_PRECHARGE; // [RULE15]
              pre_start = 1'b1;
            end
            else
            begin
              phase_next = CVDPAS_ACQUIRE;
              acq_start = 1'b1;
            end
          end
          else
          begin
            phase_next = CVDPAS_IDLE;
            second_next = 1'b0;
          end
        end
      end
      default:
        phase_next = CVDPAS_IDLE;
    endcase
  end

  // Acquisition ends by timer, or by software when untimed.
  // A done write that arrives during a timed acquisition is held but has no effect.
  assign acq_end = (pre_active_reg || !acq_zero) ? acq_expire : (sw_acq_done || sw_acq_done_reg); // [RULE10]

  // One timer serves both phases; the acquisition load follows the precharge expiry.
  assign timer_load_en = pre_start || acq_start;
  assign timer_load = pre_start ? {5'h00, precharge_time_reg} : // [RULE5]
                      (acq_zero ? CVDPAS_ACQ_MAX : acquisition_time_reg); // [RULE9]
  assign timer_run = (phase_reg == CVDPAS_PRECHARGE) || (phase_reg == CVDPAS_ACQUIRE);
  assign pre_expire = acq_expire && (phase_reg == CVDPAS_PRECHARGE);

  cvdpas_phase_timer u_timer
  (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .load_i(timer_load_en),
    .count_i(timer_load),
    .run_i(timer_run),
    .expire_o(acq_expire)
  );

  // Guard levels follow the same start pulses as the phases, so they change on phase edges.
  cvdpas_guard_drive u_guard
  (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .guard_polarity_i(ctrl_gpol),
    .second_sample_invert_enable_i(ctrl_ipen),
    .pre_start_i(pre_start),
    .acq_start_i(acq_start),
    .second_i(second_next),
    .guard_o(guard)
  );

  // Analog controls are decoded from the next phase, so the registered switches line up with phase_reg.
  always_comb
  begin
    analog_next = '0;
    case (phase_next)
      CVDPAS_PRECHARGE:
      begin
        analog_next.hold_isolate = 1'b1; // [RULE3]
        analog_next.hold_to_vdd = sample_pol_next(second_next); // [RULE3]
        analog_next.hold_to_vss = !sample_pol_next(second_next); // [RULE3]
        analog_next.pin_force_en = 1'b1; // [RULE4]
        analog_next.pin_force_level = !sample_pol_next(second_next); // [RULE4]
        analog_next.extra_cap = extra_hold_cap_select_reg; // [RULE18]
      end
      CVDPAS_ACQUIRE:
      begin
        // Supply paths and pin drive released, sensor path rejoined.
        analog_next.channel_connect = 1'b1; // [RULE8] [RULE16]
        analog_next.extra_cap = extra_hold_cap_select_reg; // [RULE18]
      end
      default:
        analog_next.extra_cap = '0; // [RULE18]
    endcase
  end

  function automatic logic sample_pol_next(input logic second);
    sample_pol_next = ctrl_precharge_polarity ^ second; // [RULE15]
  endfunction

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      phase_reg <= CVDPAS_IDLE;
      second_reg <= 1'b0;
      pre_active_reg <= 1'b0;
      analog_reg <= '0;
      sw_acq_done_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end
    else
    begin
      phase_reg <= phase_next;
      second_reg <= second_next;
      pre_active_reg <= pre_active_next;
      analog_reg <= analog_next;
      sw_acq_done_reg <= (phase_reg == CVDPAS_ACQUIRE) && !acq_end && (sw_acq_done || sw_acq_done_reg);
      rdata_reg <= rdata_next;
    end
  end

  // Read data, one cycle after the strobe; unmapped addresses read zero.
  assign rdata_next = !reg_rd_i ? 16'h0000 :
    (reg_addr_i == CVDPAS_ADDR_CTRL) ? {11'h000, double_sample_enable_reg, second_sample_invert_enable_reg,
                                        guard_polarity_reg, precharge_polarity_reg, 1'b0} :
    (reg_addr_i == CVDPAS_ADDR_PRE) ? {8'h00, precharge_time_reg} :
    (reg_addr_i == CVDPAS_ADDR_ACQ) ? {3'h0, acquisition_time_reg} :
    (reg_addr_i == CVDPAS_ADDR_CAP) ? {10'h000, extra_hold_cap_select_reg} :
    (reg_addr_i == CVDPAS_ADDR_STATUS) ? {10'h000, guard.guard_out_b, guard.guard_out_a, second_reg,
                                          phase_reg} :
    16'h0000;

  assign reg_rdata_o = rdata_reg;
  assign conv_start_o = (phase_reg == CVDPAS_CONVERT) && (analog_reg.channel_connect == 1'b0) && conv_pulse_reg;
  // Busy covers every phase but idle, so a start seen while busy is dropped.
  assign busy_o = (phase_reg != CVDPAS_IDLE);
  assign hold_isolate_o = analog_reg.hold_isolate;
  assign hold_to_vdd_o = analog_reg.hold_to_vdd;
  assign hold_to_vss_o = analog_reg.hold_to_vss;
  assign channel_connect_o = analog_reg.channel_connect;
  assign extra_hold_cap_o = analog_reg.extra_cap;
  // Forced drive wins over the direction bit while precharging.
  assign pin_oe_o = analog_reg.pin_force_en || !pin_direction_control_i; // [RULE6]
  assign pin_out_o = analog_reg.pin_force_en ? analog_reg.pin_force_level : pin_port_out_i; // [RULE6]
  assign guard_out_a_o = guard.guard_out_a;
  assign guard_out_b_o = guard.guard_out_b;

  // Conversion start pulse lines up with the analog switches leaving sampling.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      conv_pulse_reg <= 1'b0;
    else
      conv_pulse_reg <= conv_start; // [RULE17]
  end
endmodule

// ### verif/cvdpas_sensor_model.sv
// Behavioural far side: the sensor electrode and the converter core reply.
// Assumes conv_start_i is a one-cycle pulse and one conversion runs at a time.
module cvdpas_sensor_model
#(
  parameter int CONV_CYCLES = 6
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // From the sequencer
  input wire logic conv_start_i,
  input wire logic pin_out_i,
  input wire logic pin_oe_i,
  // Toward the sequencer and bench
  output logic conv_done_o,
  output logic electrode_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;

  // The electrode is a capacitor, so it keeps its charge while nothing drives it.
  always @(posedge clk_i)
  begin
    conv_done_o <= 1'b0;
    if (pin_oe_i)
      electrode_o <= pin_out_i;
    if (reset_i)
      cnt <= 0;
    else if (conv_start_i)
      cnt <= CONV_CYCLES;
    else if (cnt > 0)
    begin
      cnt <= cnt - 1;
      conv_done_o <= (cnt == 1);
    end
  end
endmodule

// ### verif/cvdpas_sequencer_asserts.sv
// Port-level checker for the capacitive divider sequencer.
// Assumes it is bound to every sequencer instance by the bind below.
module cvdpas_sequencer_asserts
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Observed outputs and pin setting
  input wire logic conv_start_o,
  input wire logic busy_o,
  input wire logic hold_isolate_o,
  input wire logic hold_to_vdd_o,
  input wire logic hold_to_vss_o,
  input wire logic channel_connect_o,
  input wire logic [5:0] extra_hold_cap_o,
  input wire logic pin_direction_control_i,
  input wire logic pin_out_o,
  input wire logic pin_oe_o,
  input wire logic guard_out_a_o,
  input wire logic guard_out_b_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sequence acq_begin_s;
    $rose(channel_connect_o) && $past(hold_isolate_o);
  endsequence

  sequence first_pre_s;
    $rose(hold_isolate_o) && !$past(busy_o);
  endsequence

  chk_pre_pin_drive: assert property (hold_isolate_o |-> pin_oe_o && (pin_out_o == hold_to_vss_o))
    else $error("pin not forced opposite to hold level");
  chk_pre_one_rail: assert property (hold_isolate_o |-> hold_to_vdd_o != hold_to_vss_o)
    else $error("hold capacitor not tied to exactly one rail");
  chk_rails_released: assert property (!hold_isolate_o |-> !hold_to_vdd_o && !hold_to_vss_o)
    else $error("rail path left on outside precharge");
  chk_acq_pin_free: assert property (channel_connect_o |-> !hold_isolate_o && (pin_oe_o == !pin_direction_control_i))
    else $error("pin still forced during acquisition");
  chk_pre_then_acq: assert property ($fell(hold_isolate_o) && busy_o |-> channel_connect_o)
    else $error("acquisition did not follow precharge");
  chk_conv_after_acq: assert property (conv_start_o |-> busy_o && !channel_connect_o && !hold_isolate_o)
    else $error("conversion started while sampling");
  chk_cap_off_conv: assert property (conv_start_o || !busy_o |-> extra_hold_cap_o == 6'h00)
    else $error("extra capacitance connected outside sampling");
  chk_guard_first_pre: assert property (first_pre_s |-> guard_out_a_o == guard_out_b_o)
    else $error("guards differ at first precharge");
  chk_guard_a_toggle: assert property (acq_begin_s |-> $changed(guard_out_a_o) && $stable(guard_out_b_o))
    else $error("guard A not toggled alone at acquisition");
  chk_conv_pulse_once: assert property ($rose(conv_start_o) |=> !conv_start_o)
    else $error("conversion start longer than one cycle");
endmodule

bind cvdpas_sequencer cvdpas_sequencer_asserts u_chk
(
  .clk_i(clk_i), .reset_i(reset_i), .conv_start_o(conv_start_o), .busy_o(busy_o),
  .hold_isolate_o(hold_isolate_o), .hold_to_vdd_o(hold_to_vdd_o), .hold_to_vss_o(hold_to_vss_o),
  .channel_connect_o(channel_connect_o), .extra_hold_cap_o(extra_hold_cap_o),
  .pin_direction_control_i(pin_direction_control_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
  .guard_out_a_o(guard_out_a_o), .guard_out_b_o(guard_out_b_o)
);

// ### verif/cvdpas_sequencer_bench.sv
// Self-checking bench for the capacitive divider sequencer.
// Assumes the sensor model answers each conversion start after a few cycles.
module cvdpas_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import cvdpas_pkg::*;
  logic clk_i, reset_i, reg_wr_i, reg_rd_i, trigger_i, restart_i, conv_done_i, conv_start_o, busy_o;
  logic hold_isolate_o, hold_to_vdd_o, hold_to_vss_o, channel_connect_o, pin_out_o, pin_oe_o;
  logic guard_out_a_o, guard_out_b_o, electrode, pin_dir;
  logic [3:0] reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o;
  logic [5:0] extra_hold_cap_o, conv_cap;
  logic [4:0] pre_snap [2];
  logic [7:0] acq_snap [2];
  int n_mismatch = 0;
  int n_compared = 0;
  logic [15:0] n_pre, n_acq, n_conv;

  cvdpas_sequencer DUT (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .trigger_i(trigger_i),
    .restart_i(restart_i), .conv_done_i(conv_done_i), .conv_start_o(conv_start_o), .busy_o(busy_o),
    .hold_isolate_o(hold_isolate_o), .hold_to_vdd_o(hold_to_vdd_o), .hold_to_vss_o(hold_to_vss_o),
    .channel_connect_o(channel_connect_o), .extra_hold_cap_o(extra_hold_cap_o),
    .pin_direction_control_i(pin_dir), .pin_port_out_i(1'b1), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
    .guard_out_a_o(guard_out_a_o), .guard_out_b_o(guard_out_b_o));

  cvdpas_sensor_model u_sensor (.clk_i(clk_i), .reset_i(reset_i), .conv_start_i(conv_start_o),
    .pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o), .conv_done_o(conv_done_i), .electrode_o(electrode));

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Snapshots keep the last cycle of each phase, so a toggle at the phase start has landed.
  always @(negedge clk_i)
  begin
    if (hold_isolate_o)
    begin
      n_pre++;
      pre_snap[n_conv[0]] = {hold_to_vdd_o, pin_out_o, pin_oe_o, guard_out_a_o, guard_out_b_o};
    end
    if (channel_connect_o)
    begin
      n_acq++;
      acq_snap[n_conv[0]] = {guard_out_a_o, guard_out_b_o, extra_hold_cap_o};
    end
    if (conv_start_o)
    begin
      n_conv++;
      conv_cap = extra_hold_cap_o;
    end
  end

  task automatic final_report();
    if (n_mismatch == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Each access leaves one idle edge so a strobe is never set twice in one time step.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 check(reg_rdata_o, exp);
    @(posedge clk_i);
  endtask

  task automatic wait_idle();
    int k = 0;
    while (busy_o !== 1'b0)
    begin
      @(posedge clk_i);
      #1;
      k++;
      if (k > 9000)
      begin
        n_mismatch++;
        final_report();
      end
    end
  endtask

  task automatic setup(input logic [15:0] pre, input logic [15:0] acq);
    wr(CVDPAS_ADDR_PRE, pre);
    wr(CVDPAS_ADDR_ACQ, acq);
    n_pre = 16'h0000;
    n_acq = 16'h0000;
    n_conv = 16'h0000;
  endtask

  task automatic run(input logic [15:0] cfg);
    wr(CVDPAS_ADDR_CTRL, cfg | 16'h0001);
    wait_idle();
  endtask

  initial
  begin
    reset_i = 1'b1;
    {reg_wr_i, reg_rd_i, trigger_i, restart_i, pin_dir} = 5'h01;
    reg_addr_i = 4'h0;
    reg_wdata_i = 16'h0000;
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    rd(CVDPAS_ADDR_PRE, 16'h0000);
    rd(CVDPAS_ADDR_ACQ, 16'h0000);
    rd(CVDPAS_ADDR_CAP, 16'h0000);
    wr(4'hF, 16'hFFFF);
    rd(4'hF, 16'h0000);
    wr(CVDPAS_ADDR_ACQ, 16'hFFFF);
    rd(CVDPAS_ADDR_ACQ, 16'h1FFF);
    wr(CVDPAS_ADDR_CAP, 16'h002A);
    // Single sample, hold to supply, guards low.
    setup(16'h0005, 16'h0004);
    run(16'h0002);
    check(n_pre, 16'h0005);
    check(n_acq, 16'h0004);
    check(n_conv, 16'h0001);
    check(pre_snap[0], 16'h0014);
    check(acq_snap[0], 16'h00AA);
    check(conv_cap, 16'h0000);
    check(electrode, 16'h0000);
    // Double sample with inverted second precharge and guard inversion.
    setup(16'h0005, 16'h0004);
    run(16'h001C);
    check(n_pre, 16'h000A);
    check(n_acq, 16'h0008);
    check(n_conv, 16'h0002);
    check(pre_snap[0], 16'h000F);
    check(pre_snap[1], 16'h0014);
    check(acq_snap[0], 16'h006A);
    check(acq_snap[1], 16'h00AA);
    rd(CVDPAS_ADDR_CTRL, 16'h001C);
    wr(CVDPAS_ADDR_CTRL, 16'h0000);
    // Hardware trigger and computation restart; a second trigger while busy is ignored.
    for (int i = 0; i < 2; i++)
    begin
      setup(16'h0003, 16'h0002);
      trigger_i <= (i == 0);
      restart_i <= (i == 1);
      @(posedge clk_i);
      trigger_i <= 1'b0;
      restart_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      trigger_i <= 1'b1;
      @(posedge clk_i);
      trigger_i <= 1'b0;
      wait_idle();
      check(n_pre, 16'h0003);
      check(n_conv, 16'h0001);
    end
    // No precharge: acquisition at once.
    setup(16'h0000, 16'h0003);
    run(16'h0000);
    check(n_pre, 16'h0000);
    check(n_acq, 16'h0003);
    // No precharge and zero acquisition: software ends acquisition.
    setup(16'h0000, 16'h0000);
    wr(CVDPAS_ADDR_CTRL, 16'h0001);
    repeat (40) @(posedge clk_i);
    #1 check(channel_connect_o, 16'h0001);
    check(n_conv, 16'h0000);
    pin_dir <= 1'b0;
    rd(CVDPAS_ADDR_STATUS, 16'h0012);
    check({pin_oe_o, pin_out_o}, 16'h0003);
    @(posedge clk_i);
    wr(CVDPAS_ADDR_CTRL, 16'h0020);
    wait_idle();
    check(n_conv, 16'h0001);
    // Precharge on and zero acquisition: longest acquisition.
    setup(16'h0002, 16'h0000);
    run(16'h0000);
    check(n_pre, 16'h0002);
    check(n_acq, 16'h1FFF);
    final_report();
  end
endmodule
